// ---- src/swm_regs.vh ----
// register map, field positions, reset values and timing counts for the
// stop-wake, watchdog and supply monitor block; definitions only
`ifndef SWM_REGS_VH
`define SWM_REGS_VH

// register indices; byte address is four times the index
`define SWM_IDX_WAKE_CTL    6'h0b
`define SWM_IDX_SUPPLY      6'h0c
`define SWM_IDX_WAKE_CTL2   6'h0d
`define SWM_IDX_WD_SETUP    6'h0f
`define SWM_IDX_IRQ_REQ     6'h1a
`define SWM_IDX_IRQ_MASK    6'h1b

// field positions
`define SWM_SRC_MSB         4
`define SWM_SRC_LSB         2
`define SWM_DELAY_BIT       5
`define SWM_LEVEL_BIT       6
`define SWM_START_BIT       7
`define SWM_LEVEL2_BIT      6
`define SWM_MON_EN_BIT      0
`define SWM_LOW_BIT         1
`define SWM_HIGH_BIT        2
`define SWM_SUPPLY_IRQ_BIT  5
`define SWM_WD_HALT_BIT     2
`define SWM_WD_STOP_BIT     3

// reset values
`define SWM_WAKE_CTL_RST    8'h20
`define SWM_WAKE_CTL2_RST   8'h00
`define SWM_WD_SETUP_RST    8'h04
`define SWM_IRQ_MASK_RST    8'h00

// timing
`define SWM_CLK_HZ          40000000
`define SWM_WIN_CLKS        7'd120
`define SWM_TPOR_US         5000
`define SWM_TPOR_CYCLES     (`SWM_TPOR_US * (`SWM_CLK_HZ / 1000000))
`define SWM_RC_PERIOD_US    100
`define SWM_WD_T0_MS        5
`define SWM_WD_T1_MS        10
`define SWM_WD_T2_MS        20
`define SWM_WD_T3_MS        80
`define SWM_WD_TICKS(ms)    (((ms) * 1000 + `SWM_RC_PERIOD_US - 1) / `SWM_RC_PERIOD_US)

`endif

// ---- src/swm_watchdog.v ----
// retriggerable watchdog counting ticks of the internal rc oscillator
// assumes rc_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "swm_regs.vh"

module swm_watchdog (
  input  wire       clk,
  input  wire       reset,
  input  wire       rc_tick,
  input  wire       kick,
  input  wire       run_ok,
  input  wire [1:0] period,
  output reg        started,
  output reg        timeout
);

  localparam integer LIM0_W = `SWM_WD_TICKS(`SWM_WD_T0_MS);
  localparam integer LIM1_W = `SWM_WD_TICKS(`SWM_WD_T1_MS);
  localparam integer LIM2_W = `SWM_WD_TICKS(`SWM_WD_T2_MS);
  localparam integer LIM3_W = `SWM_WD_TICKS(`SWM_WD_T3_MS);
  localparam [9:0]   LIM0   = LIM0_W[9:0];
  localparam [9:0]   LIM1   = LIM1_W[9:0];
  localparam [9:0]   LIM2   = LIM2_W[9:0];
  localparam [9:0]   LIM3   = LIM3_W[9:0];

  reg [9:0] count;

  // tap select for the minimum timeout
  function [9:0] limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    limit = LIM0;
        2'h1:    limit = LIM1;
        2'h2:    limit = LIM2;
        default: limit = LIM3;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      started <= 1'b0;
      count   <= 10'h000;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (kick) begin
        started <= 1'b1;
        count   <= 10'h000;
      end else if (started && run_ok && rc_tick) begin
        if (count >= limit(period) - 10'h001) begin
          count   <= 10'h000;
          timeout <= 1'b1;
        end else begin
          count <= count + 10'h001;
        end
      end
    end
  end

endmodule // swm_watchdog
`default_nettype wire

// ---- src/swm_top.v ----
// stop-mode wake selection, recovery sequencing, watchdog and supply monitor
// assumes an AHB-Lite master with single word transfers; pins synchronous to clk
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "swm_regs.vh"

// Summary of operation
// - primary wake source: reset only, reserved, four pins, port-2 NOR of 4 or 8
// - port-2 lines set as outputs present their inactive state to wake gates
// - delay bit 0 skips power-on delay after wake; 1, the default, inserts it
// - level bit picks high or low wake polarity; zero after reset
// - start-type bit reads 1 after stop wake, 0 after any other reset
// - secondary wake source: NAND/NOR groups of port-2, port-3 and port-0 lines
// - with both sources programmed either one wakes the device
// - watchdog is retriggerable and stays started once kicked, resetting the core at every terminal count
// - kick instruction starts the watchdog, later kicks restart its count
// - watchdog counts ticks of the internal rc oscillator
// - watchdog setup writable only 120 clocks after reset, watchdog reset or wake
// - watchdog setup is write only and reads as zero
// - period field picks 5, 10, 20 or 80 ms minimum timeout
// - watchdog setup bit 2, default 1, keeps the watchdog running in halt
// - bit 3 keeps the watchdog running in stop; bits 7..4 reserved
// - supply bit 0 enables monitoring; bit 2 high-voltage, bit 1 low-voltage flag
// - low-voltage flag latches interrupt request bit 5 until cleared or reset
// - supply interrupt leaves only when masked in; otherwise it is a polled flag
module swm_top #(
  parameter TPOR_CYCLES = `SWM_TPOR_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        stop_request,
  input  wire        halt_active,
  input  wire        watchdog_kick_instruction,
  input  wire        rc_tick,
  input  wire        vcc_above_high,
  input  wire        vcc_below_low,
  input  wire [7:0]  port2_in,
  input  wire [7:0]  port2_is_output,
  input  wire [3:0]  port3_in,
  input  wire [7:0]  port0_in,
  output reg         core_run,
  output reg         core_reset,
  output reg         supply_irq
);

  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_STOP  = 2'h1;
  localparam [1:0] ST_DELAY = 2'h2;
  localparam [17:0] TPOR_LAST = TPOR_CYCLES[17:0] - 18'h00001;

  reg  [7:0]  stop_wake_control;
  reg  [7:0]  stop_wake_control_second;
  reg  [7:0]  watchdog_setup;
  reg  [7:0]  interrupt_mask_reg;
  reg         mon_enable;
  reg         supply_interrupt_request;
  reg         start_type;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [17:0] delay_cnt;
  reg  [6:0]  win_cnt;
  reg         wr_pend;
  reg  [5:0]  wr_idx;
  reg  [7:0]  rd_val;
  wire        wd_started;
  wire        wd_timeout;
  wire        wd_run_ok;
  wire        addr_ok;
  wire [5:0]  idx;
  wire [7:0]  p2_nor;
  wire [7:0]  p2_nand;
  wire        wake_one;
  wire        wake_two;
  wire        wake_hit;
  wire        over_voltage_flag;
  wire        low_voltage_flag;
  wire        wr_data_ev;
  wire        clear_req;
  wire        next_req;

  //////////////////////////////////////////////////////////////////////////////
  // wake source selection

  // output lines forced to the level that cannot trip the gate
  assign p2_nor  = port2_in & ~port2_is_output;
  assign p2_nand = port2_in | port2_is_output;

  function primary_src;
    input [2:0] sel;
    input [7:0] pn;
    input [3:0] p3;
    input       p27;
    begin
      case (sel)
        3'h2:    primary_src = p3[1];
        3'h3:    primary_src = p3[2];
        3'h4:    primary_src = p3[3];
        3'h5:    primary_src = p27;
        3'h6:    primary_src = ~|pn[3:0];
        3'h7:    primary_src = ~|pn;
        default: primary_src = 1'b0;
      endcase
    end
  endfunction

  function secondary_src;
    input [2:0] sel;
    input [7:0] pa;
    input [3:0] p3;
    input [7:0] p0;
    begin
      case (sel)
        3'h1:    secondary_src = ~&pa[3:0];
        3'h2:    secondary_src = ~&pa;
        3'h3:    secondary_src = ~|p3[3:1];
        3'h4:    secondary_src = ~&p3[3:1];
        3'h5:    secondary_src = ~|{p3[3:1], p0[0], p0[7]};
        3'h6:    secondary_src = ~&{p3[3:1], p0[0], p0[7]};
        3'h7:    secondary_src = ~&{p3[3:1], pa[2:0]};
        default: secondary_src = 1'b0;
      endcase
    end
  endfunction

  // a source is live only when its select names a real source
  assign wake_one = (stop_wake_control[`SWM_SRC_MSB:`SWM_SRC_LSB] > 3'h1)
                    && (primary_src(stop_wake_control[`SWM_SRC_MSB:`SWM_SRC_LSB], p2_nor,
                                    port3_in, port2_in[7]) == stop_wake_control[`SWM_LEVEL_BIT]);
  assign wake_two = (stop_wake_control_second[`SWM_SRC_MSB:`SWM_SRC_LSB] != 3'h0)
                    && (secondary_src(stop_wake_control_second[`SWM_SRC_MSB:`SWM_SRC_LSB], p2_nand,
                                      port3_in, port0_in) == stop_wake_control_second[`SWM_LEVEL2_BIT]);
  assign wake_hit = wake_one | wake_two;

  //////////////////////////////////////////////////////////////////////////////
  // watchdog

  // pauses in halt or stop unless the matching setup bit keeps it running
  assign wd_run_ok = !(halt_active && !watchdog_setup[`SWM_WD_HALT_BIT])
                     && !((state != ST_RUN) && !watchdog_setup[`SWM_WD_STOP_BIT]);

  swm_watchdog u_watchdog (
    .clk     (clk),
    .reset   (reset),
    .rc_tick (rc_tick),
    .kick    (watchdog_kick_instruction && core_run),
    .run_ok  (wd_run_ok),
    .period  (watchdog_setup[1:0]),
    .started (wd_started),
    .timeout (wd_timeout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // stop and recovery sequencing

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stop_request)
          next_state = ST_STOP;
      end
      ST_STOP: begin
        if (wd_timeout)
          next_state = ST_RUN;
        else if (wake_hit)
          next_state = stop_wake_control[`SWM_DELAY_BIT] ? ST_DELAY : ST_RUN;
      end
      ST_DELAY: begin
        if (wd_timeout || delay_cnt == TPOR_LAST)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= ST_RUN;
      delay_cnt  <= 18'h00000;
      win_cnt    <= `SWM_WIN_CLKS;
      start_type <= 1'b0;
      core_run   <= 1'b1;
      core_reset <= 1'b0;
    end else begin
      state      <= next_state;
      core_run   <= (next_state == ST_RUN);
      core_reset <= wd_timeout;
      if (state == ST_DELAY)
        delay_cnt <= delay_cnt + 18'h00001;
      else
        delay_cnt <= 18'h00000;
      if (wd_timeout)
        start_type <= 1'b0;
      else if (state == ST_STOP && wake_hit)
        start_type <= 1'b1;
      // window reopens when the core is released again
      if (wd_timeout || (state != ST_RUN && next_state == ST_RUN))
        win_cnt <= `SWM_WIN_CLKS;
      else if (state == ST_RUN && win_cnt != 7'h00)
        win_cnt <= win_cnt - 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // supply monitor

  assign over_voltage_flag = mon_enable && vcc_above_high;
  assign low_voltage_flag  = mon_enable && vcc_below_low;
  assign wr_data_ev = wr_pend && hready;
  assign clear_req  = wr_data_ev && wr_idx == `SWM_IDX_IRQ_REQ && hwdata[`SWM_SUPPLY_IRQ_BIT];
  // a new low reading wins over a clear in the same cycle
  assign next_req   = low_voltage_flag || (supply_interrupt_request && !clear_req);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      supply_interrupt_request <= 1'b0;
      supply_irq               <= 1'b0;
    end else begin
      supply_interrupt_request <= next_req;
      supply_irq               <= next_req && interrupt_mask_reg[`SWM_SUPPLY_IRQ_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus slave

  assign idx     = haddr[7:2];
  assign addr_ok = hsel && hready && htrans[1];

  always @* begin
    case (idx)
      `SWM_IDX_WAKE_CTL: rd_val = {start_type, 7'h00};
      `SWM_IDX_SUPPLY:   rd_val = {5'h00, over_voltage_flag, low_voltage_flag, mon_enable};
      `SWM_IDX_IRQ_REQ:  rd_val = {2'h0, supply_interrupt_request, 5'h00};
      `SWM_IDX_IRQ_MASK: rd_val = interrupt_mask_reg;
      default:           rd_val = 8'h00;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_idx    <= 6'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend <= addr_ok && hwrite && haddr[31:8] == 24'h000000;
        wr_idx  <= idx;
      end
      if (addr_ok && !hwrite)
        hrdata <= (haddr[31:8] == 24'h000000) ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stop_wake_control        <= `SWM_WAKE_CTL_RST;
      stop_wake_control_second <= `SWM_WAKE_CTL2_RST;
      watchdog_setup           <= `SWM_WD_SETUP_RST;
      interrupt_mask_reg       <= `SWM_IRQ_MASK_RST;
      mon_enable               <= 1'b0;
    end else if (wr_data_ev) begin
      case (wr_idx)
        `SWM_IDX_WAKE_CTL:  stop_wake_control <= {1'b0, hwdata[6:2], 2'h0};
        `SWM_IDX_WAKE_CTL2: stop_wake_control_second <= {1'b0, hwdata[6], 1'b0, hwdata[4:2], 2'h0};
        `SWM_IDX_SUPPLY:    mon_enable <= hwdata[`SWM_MON_EN_BIT];
        `SWM_IDX_IRQ_MASK:  interrupt_mask_reg <= hwdata[7:0];
        `SWM_IDX_WD_SETUP: begin
          if (win_cnt != 7'h00)
            watchdog_setup <= {4'h0, hwdata[3:0]};
        end
        default: mon_enable <= mon_enable;
      endcase
    end
  end

endmodule // swm_top
`default_nettype wire

// ---- bench/swm_far_model.sv ----
// far side model: wake pins as the outside world drives them
// assumes pin_req from the bench; each new level is held ten clocks at least
`timescale 1ns/10ps
`default_nettype none
module swm_far_model (
  input  wire logic        clk,
  input  wire logic [19:0] pin_req,
  output wire logic [7:0]  port2_in,
  output wire logic [3:0]  port3_in,
  output wire logic [7:0]  port0_in
);
  logic [19:0] pins = 20'h0;
  logic [3:0]  hold = 4'h0;
  ////////////////////////////////////////
  assign {port0_in, port3_in, port2_in} = pins;
  always @(posedge clk) begin
    if (hold != 4'h0)
      hold <= hold - 4'h1;
    else if (pins != pin_req) begin
      pins <= pin_req;
      hold <= 4'ha;
    end
  end
endmodule // swm_far_model
`default_nettype wire

// ---- bench/swm_sva.sv ----
// checker for swm_top: bus answer, stop entry, wake delay, watchdog reset, supply request
// assumes it is bound into swm_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "swm_regs.vh"
module swm_sva #(
  parameter TPOR_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        stop_request,
  input wire logic        rc_tick,
  input wire logic        core_run,
  input wire logic        core_reset,
  input wire logic        supply_irq
);
  logic        wr_ph;
  logic [5:0]  wr_idx;
  logic [1:0]  wr_age;
  logic        dly;
  logic [31:0] low_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // shadow of the delay bit, age of writes, length of the stopped span
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ph  <= 1'b0;
      wr_idx <= 6'h0;
      wr_age <= 2'h0;
      dly    <= 1'b1;
      low_n  <= 32'h0;
    end else begin
      wr_ph  <= hsel && hready && htrans[1] && hwrite;
      wr_idx <= haddr[7:2];
      wr_age <= {wr_age[0], wr_ph};
      if (wr_ph && wr_idx == `SWM_IDX_WAKE_CTL)
        dly <= hwdata[`SWM_DELAY_BIT];
      low_n  <= core_run ? 32'h0 : low_n + 32'h1;
    end
  end
  ////////////////////////////////////////
  bus_ready_a: assert property (hreadyout)
    else $error("hreadyout low");
  bus_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  stop_entry_a: assert property (core_run && stop_request && !core_reset |-> ##[1:2] !core_run)
    else $error("core kept running after stop");
  wake_delay_a: assert property ($rose(core_run) && dly && !core_reset && !$past(core_reset) |->
    low_n >= TPOR_CYCLES) else $error("wake came before the power-on delay");
  irq_latch_a: assert property (supply_irq && !wr_ph && wr_age == 2'h0 && !core_reset |=> supply_irq)
    else $error("supply request dropped without a clear");
  reset_pulse_a: assert property (core_reset |=> !core_reset)
    else $error("core reset longer than one cycle");
  reset_tick_a: assert property ($rose(core_reset) |-> $past(rc_tick) || $past(rc_tick, 2) || $past(rc_tick, 3))
    else $error("core reset without an rc tick");
endmodule // swm_sva
bind swm_top swm_sva #(.TPOR_CYCLES(TPOR_CYCLES)) u_sva (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .stop_request(stop_request), .rc_tick(rc_tick), .core_run(core_run), .core_reset(core_reset),
  .supply_irq(supply_irq));
`default_nettype wire

// ---- bench/swm_top_tb_top.sv ----
// bench top: registers, watchdog, wake sources and supply request of swm_top
// assumes the far model drives the wake pins and a short power-on delay
`timescale 1ns/10ps
`default_nettype none
`include "swm_regs.vh"
module swm_top_tb_top;
  localparam TP = 20;
  typedef struct packed {logic [7:0] c, c2, o; logic [19:0] i, a;} swm_row_t;
  logic        clk, reset, hwrite, hreadyout, hresp, stop_request, kick, rc_tick, hi, lo;
  logic        core_run, core_reset, supply_irq, halt;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  p2out, p2, p0;
  logic [3:0]  p3;
  logic [19:0] pin_req;
  int          fails, checks, resets, n;
  int          lim [4] = '{50, 100, 200, 800};
  // first byte: bit 6 set means write, low six bits the index
  logic [23:0] regs [9] = '{24'h0b_00_00, 24'h0c_00_00, 24'h0d_00_00, 24'h0f_00_00, 24'h1a_00_00,
                            24'h1b_00_00, 24'h4d_5c_00, 24'h4c_01_01, 24'h7f_55_00};
  // control, control 2, port-2 outputs, idle pins, waking pins as {port0, port3, port2}
  swm_row_t    rows [17] = '{64'h48_00_00_00000_00200, 64'h4c_00_00_00000_00400, 64'h50_00_00_00000_00800,
    64'h54_00_00_00000_00080, 64'h58_00_00_00001_000f0, 64'h5c_00_00_00080_00000, 64'h58_00_01_00002_00001,
    64'h08_00_00_00200_00000, 64'h68_00_00_00000_00200, 64'h40_44_00_fff0f_ffffe, 64'h40_48_00_fffff_fff7f,
    64'h40_4c_00_fffff_ff1ff, 64'h40_50_00_fffff_ffdff, 64'h40_54_00_fffff_7e1ff, 64'h40_58_00_fffff_fefff,
    64'h40_5c_00_fffff_ffffb, 64'h48_4c_00_00400_00000};
  swm_top #(.TPOR_CYCLES(TP)) DUT (.clk(clk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .stop_request(stop_request), .halt_active(halt), .watchdog_kick_instruction(kick),
    .rc_tick(rc_tick), .vcc_above_high(hi), .vcc_below_low(lo), .port2_in(p2), .port2_is_output(p2out),
    .port3_in(p3), .port0_in(p0), .core_run(core_run), .core_reset(core_reset), .supply_irq(supply_irq));
  swm_far_model u_far (.clk(clk), .pin_req(pin_req), .port2_in(p2), .port3_in(p3), .port0_in(p0));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (core_reset === 1'b1) resets++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] x, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, x, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [5:0] x, input logic [31:0] d);
    bus(1'b1, x, d);
  endtask
  task automatic rdr(input logic [5:0] x);
    bus(1'b0, x, 32'h0);
  endtask
  task automatic pulse_kick;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      rc_tick <= 1'b1;
      @(posedge clk);
      rc_tick <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    {reset, hwrite, stop_request, kick, rc_tick, hi, lo, halt} = 8'h80;
    {htrans, haddr, hwdata, p2out, pin_req} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (regs[r]) begin
      if (regs[r][22]) wr(regs[r][21:16], regs[r][15:8]);
      rdr(regs[r][21:16]);
      chk(rd, regs[r][7:0]);
    end
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr(`SWM_IDX_WD_SETUP, p);
      pulse_kick();
      n = resets;
      ticks(lim[p] - 10);
      pulse_kick();
      ticks(lim[p] - 1);
      chk(resets, n);
      ticks(1);
      chk(resets, n + 1);
    end
    repeat (130) @(posedge clk);
    wr(`SWM_IDX_WD_SETUP, 0);
    pulse_kick();
    n = resets;
    ticks(60);
    chk(resets, n);
    $display("test watchdog done");
    foreach (rows[r]) begin
      wr(`SWM_IDX_WAKE_CTL, rows[r].c);
      wr(`SWM_IDX_WAKE_CTL2, rows[r].c2);
      p2out <= rows[r].o;
      pin_req <= rows[r].i;
      repeat (14) @(posedge clk);
      stop_request <= 1'b1;
      @(posedge clk);
      stop_request <= 1'b0;
      repeat (12) @(posedge clk);
      chk(core_run, 0);
      pin_req <= rows[r].a;
      n = 0;
      while (core_run !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk(n < 200, 1);
      chk(n > TP, rows[r].c[5]);
      rdr(`SWM_IDX_WAKE_CTL);
      chk(rd, 32'h80);
    end
    $display("test wake sources done");
    // window reopened by the last wake: halt pauses, stop keeps counting
    wr(`SWM_IDX_WD_SETUP, 32'h08);
    wr(`SWM_IDX_WAKE_CTL, 32'h40);
    pin_req <= 20'hfffff;
    pulse_kick();
    halt <= 1'b1;
    n = resets;
    ticks(60);
    chk(resets, n);
    halt <= 1'b0;
    stop_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    ticks(50);
    chk(resets, n + 1);
    chk(core_run, 1);
    $display("test halt and stop done");
    wr(`SWM_IDX_SUPPLY, 1);
    lo <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(`SWM_IDX_SUPPLY);
    chk(rd, 32'h03);
    rdr(`SWM_IDX_IRQ_REQ);
    chk(rd, 32'h20);
    chk(supply_irq, 0);
    wr(`SWM_IDX_IRQ_MASK, 32'h20);
    lo <= 1'b0;
    hi <= 1'b1;
    repeat (3) @(posedge clk);
    chk(supply_irq, 1);
    rdr(`SWM_IDX_SUPPLY);
    chk(rd, 32'h05);
    wr(`SWM_IDX_IRQ_REQ, 32'h20);
    repeat (3) @(posedge clk);
    chk(supply_irq, 0);
    $display("test supply done");
    wr(`SWM_IDX_WAKE_CTL, 32'h44);
    stop_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    pin_req <= 20'hfffff;
    repeat (30) @(posedge clk);
    chk(core_run, 0);
    reset <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(core_run, 1);
    reset <= 1'b0;
    @(posedge clk);
    rdr(`SWM_IDX_WAKE_CTL);
    chk(rd, 32'h00);
    $display("test reserved source and reset done");
    test_done;
  end
endmodule // swm_top_tb_top
`default_nettype wire
